/* verilog/enc_latch_force.v */
/*
 * enc_latch_force: latch, force and status logic of an incremental
 * encoder channel. holds the counter and the control/status words.
 * assumes the host writes words by word strobes with data, and the
 * encoder, reference and switch pins are asynchronous to clock.
 *
 */
`timescale 1ns/1ps
`include "enc_latch_defs.vh"
module enc_latch_force #(
    parameter WIDTH = 32,
    parameter FILTER_LEN = `FILTER_LEN
) (
    input wire clock,
    input wire rst_b,
    input wire clock_enable,
    input wire enc_a,
    input wire enc_b,
    input wire ref_pulse,
    input wire ref_switch,
    input wire supply_ok,
    input wire homing_active,
    input wire comparator_on,
    input wire cfg_write,
    input wire [15:0] cfg_wdata,
    input wire param1_write,
    input wire [31:0] param1_wdata,
    input wire param2_write,
    input wire [31:0] param2_wdata,
    output reg [15:0] cfg_rdata,
    output reg [15:0] status_rdata,
    output reg [15:0] module_code_rdata,
    output reg [31:0] counter_out,
    output reg [31:0] rise_latch,
    output reg [31:0] fall_latch
);
    // capture and force timing bounds, in cycles of clock
    localparam integer LATCH_MAX_CYC =
        `LATCH_MAX_NS / (1000000000 / `CLOCK_HZ);
    localparam integer FORCE_MAX_CYC =
        `FORCE_MAX_NS / (1000000000 / `CLOCK_HZ);

    // ************************************************************
    // input synchronisers
    // ************************************************************
    reg [4:0] sync1_q;
    reg [4:0] sync2_q;
    wire a_s = sync2_q[0];
    wire b_s = sync2_q[1];
    wire ref_s = sync2_q[2];
    wire sw_s = sync2_q[3];
    wire sup_s = sync2_q[4];

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            sync1_q <= 5'h00;
            sync2_q <= 5'h00;
        end else if (clock_enable) begin
            sync1_q <= {supply_ok, ref_switch, ref_pulse, enc_b, enc_a};
            sync2_q <= sync1_q;
        end
    end

    // ************************************************************
    // control word and rise detection
    // ************************************************************
    reg [15:0] cfg_q;
    wire [15:0] cfg_new = cfg_wdata & `CFG_WRITE_MASK;
    wire wr = cfg_write & clock_enable;
    wire rise_force = wr & cfg_new[`CFG_FORCE_ARM] & ~cfg_q[`CFG_FORCE_ARM];
    wire rise_rl = wr & cfg_new[`CFG_LATCH_RISE] & ~cfg_q[`CFG_LATCH_RISE];
    wire rise_fl = wr & cfg_new[`CFG_LATCH_FALL] & ~cfg_q[`CFG_LATCH_FALL];
    wire rise_par = wr & cfg_new[`CFG_PARAM_SEL] & ~cfg_q[`CFG_PARAM_SEL];
    wire fall_rl = wr & ~cfg_new[`CFG_LATCH_RISE];
    wire fall_fl = wr & ~cfg_new[`CFG_LATCH_FALL];

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_q <= `CFG_RESET;
        end else if (wr) begin
            cfg_q <= cfg_new;
        end
    end

    // ************************************************************
    // parameter words
    // ************************************************************
    reg [31:0] p1_q;
    reg [31:0] p2_q;
    reg [31:0] min_diff_q;
    reg [31:0] force_val_q;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            p1_q <= 32'h00000000;
            p2_q <= 32'h00000000;
            min_diff_q <= 32'h00000000;
            force_val_q <= 32'h00000000;
        end else if (clock_enable) begin
            if (param1_write) begin
                p1_q <= param1_wdata;
            end
            if (param2_write) begin
                p2_q <= param2_wdata;
            end
            // taken in the write cycle: well inside the force bound
            if (rise_par) begin
                min_diff_q <= p1_q;
                force_val_q <= p2_q;
            end
        end
    end

    // ************************************************************
    // reference input filter
    // ************************************************************
    wire ref_f;
    reg ref_f_q;
    wire filt_load = rise_rl | rise_fl;

    edge_filter #(
        .LEN(FILTER_LEN)
    ) u_filter (
        .clock(clock),
        .rst_b(rst_b),
        .enable(clock_enable),
        .load(filt_load),
        .load_value(cfg_new[`CFG_FILT_START]),
        .din(ref_s),
        .dout(ref_f)
    );

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            ref_f_q <= 1'b0;
        end else if (clock_enable) begin
            if (filt_load) begin
                ref_f_q <= cfg_new[`CFG_FILT_START];
            end else begin
                ref_f_q <= ref_f;
            end
        end
    end

    // latching yields to homing and to the comparator
    wire latch_ok = ~homing_active & ~comparator_on;
    wire ref_rise = ~filt_load & ref_f & ~ref_f_q;
    wire ref_fall = ~filt_load & ~ref_f & ref_f_q;

    // ************************************************************
    // quadrature counter and force
    // ************************************************************
    reg a_q;
    reg b_q;
    reg [WIDTH-1:0] count_q;
    reg sw_q;
    reg force_armed_q;
    reg referenced_q;
    reg ref_toggle_q;
    wire sw_pol = sw_s ^ cfg_q[`CFG_SW_POL];
    wire sw_rise = sw_pol & ~sw_q;
    wire do_force = force_armed_q & sw_rise;
    wire step = (a_s ^ a_q) | (b_s ^ b_q);
    wire up = a_q ^ b_s;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            sw_q <= 1'b0;
            count_q <= {WIDTH{1'b0}};
            force_armed_q <= 1'b0;
            referenced_q <= 1'b0;
            ref_toggle_q <= 1'b0;
        end else if (clock_enable) begin
            a_q <= a_s;
            b_q <= b_s;
            sw_q <= sw_pol;
            if (rise_force) begin
                referenced_q <= 1'b0;
                force_armed_q <= 1'b1;
            end else if (do_force) begin
                force_armed_q <= 1'b0;
                referenced_q <= 1'b1;
                ref_toggle_q <= ~ref_toggle_q;
            end
            // forcing is homing: it overrides counting
            if (do_force) begin
                count_q <= force_val_q[WIDTH-1:0];
            end else if (step) begin
                count_q <= up ? count_q + 1'b1 : count_q - 1'b1;
            end
        end
    end

    // ************************************************************
    // latch units, one per edge direction
    // ************************************************************
    reg [31:0] cmp_q;
    reg [1:0] armed_q;
    reg [1:0] valid_q;
    wire [1:0] start = {rise_rl, rise_fl};
    wire [1:0] stop = {fall_rl, fall_fl};
    wire [1:0] hit = {ref_rise, ref_fall};
    wire [31:0] cnt32 = count_q;
    wire [31:0] diff = cnt32 - cmp_q;
    // zero minimum takes the edge directly
    wire pass = (min_diff_q == 32'h00000000) | (diff > min_diff_q);

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cmp_q <= 32'h00000000;
        end else if (clock_enable && (rise_rl | rise_fl)) begin
            cmp_q <= cnt32;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_latch
            always @(posedge clock or negedge rst_b) begin
                if (!rst_b) begin
                    armed_q[i] <= 1'b0;
                    valid_q[i] <= 1'b0;
                end else if (clock_enable) begin
                    if (start[i]) begin
                        armed_q[i] <= 1'b1;
                        valid_q[i] <= 1'b0;
                    end else if (stop[i]) begin
                        armed_q[i] <= 1'b0;
                        valid_q[i] <= 1'b0;
                    end else if (armed_q[i] && hit[i] && latch_ok) begin
                        if (pass) begin
                            // one capture per enable
                            armed_q[i] <= 1'b0;
                            valid_q[i] <= 1'b1;
                        end
                    end
                end
            end
        end
    endgenerate

    // ************************************************************
    // outputs
    // ************************************************************
    wire take_r = armed_q[1] & hit[1] & latch_ok & pass & ~start[1] &
        ~stop[1];
    wire take_f = armed_q[0] & hit[0] & latch_ok & pass & ~start[0] &
        ~stop[0];
    wire [15:0] status = {4'h0, valid_q[1], valid_q[0], 2'b00,
        referenced_q, ref_toggle_q, sup_s, 1'b0, a_s, b_s, sw_s, ref_s};

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cfg_rdata <= `CFG_RESET;
            status_rdata <= 16'h0000;
            module_code_rdata <= 16'h0000;
            counter_out <= 32'h00000000;
            rise_latch <= 32'h00000000;
            fall_latch <= 32'h00000000;
        end else if (clock_enable) begin
            cfg_rdata <= cfg_q;
            status_rdata <= status;
            module_code_rdata <= {`MODULE_CODE, 8'h00};
            counter_out <= cnt32;
            if (take_r) begin
                rise_latch <= cnt32;
            end
            if (take_f) begin
                fall_latch <= cnt32;
            end
        end
    end
endmodule

/* include/enc_latch_defs.vh */
/*
 * register field positions, reset values and timing constants of the
 * encoder latch and force control block.
 * assumes inclusion by bare name from the design files.
 */
`ifndef ENC_LATCH_DEFS_VH
`define ENC_LATCH_DEFS_VH

// ************************************************************
// control word fields
// ************************************************************
`define CFG_SW_POL 13
`define CFG_FORCE_ARM 12
`define CFG_LATCH_RISE 11
`define CFG_LATCH_FALL 10
`define CFG_FILT_START 9
`define CFG_PARAM_SEL 8
`define CFG_WRITE_MASK 16'h3f00
`define CFG_RESET 16'h0000

// ************************************************************
// status word fields
// ************************************************************
`define ST_RISE_VALID 11
`define ST_FALL_VALID 10
`define ST_REFERENCED 7
`define ST_REF_TOGGLE 6
`define ST_SUPPLY_OK 5
`define ST_ENC_A 3
`define ST_ENC_B 2
`define ST_SWITCH 1
`define ST_REF_PULSE 0

// ************************************************************
// identity and timing
// ************************************************************
// module code value is arbitrary
`define MODULE_CODE 8'h5a
`define CLOCK_HZ 40000000
`define LATCH_MAX_NS 50000
`define FORCE_MAX_NS 1000000
`define FILTER_LEN 4

`endif

/* verilog/edge_filter.v */
/*
 * edge_filter: majority-free run-length filter for the reference input.
 * output follows the input after it has been stable for len cycles.
 * assumes the input is already synchronised; load sets the start state.
 */
`timescale 1ns/1ps
module edge_filter #(
    parameter LEN = 4
) (
    input wire clock,
    input wire rst_b,
    input wire enable,
    input wire load,
    input wire load_value,
    input wire din,
    output reg dout
);
    reg [7:0] run_q;

    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            dout <= 1'b0;
            run_q <= 8'h00;
        end else if (enable) begin
            if (load) begin
                // start state may differ from input: an edge then follows
                dout <= load_value;
                run_q <= 8'h00;
            end else if (din == dout) begin
                run_q <= 8'h00;
            end else if (run_q == LEN[7:0] - 8'h01) begin
                dout <= din;
                run_q <= 8'h00;
            end else begin
                run_q <= run_q + 8'h01;
            end
        end
    end
endmodule

/* verification/elf_checker.sv */
/* port assertions of enc_latch_force, bound to every instance.
   assumes one clock domain and the registered outputs of the block. */
`timescale 1ns/1ps
`include "enc_latch_defs.vh"
// ********
// checker
// ********
module elf_checker (
    input wire clock,
    input wire rst_b,
    input wire supply_ok,
    input wire homing_active,
    input wire cfg_write,
    input wire [15:0] cfg_wdata,
    input wire [15:0] cfg_rdata,
    input wire [15:0] status_rdata,
    input wire [15:0] module_code_rdata,
    input wire [31:0] rise_latch,
    input wire [31:0] fall_latch
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    a_reserved_zero: assert property (
        cfg_rdata[15:14] == 2'h0 && cfg_rdata[7:0] == 8'h00)
        else $error("reserved control bits not zero");
    a_code_high: assert property (
        $past(rst_b, 2) |-> module_code_rdata[15:8] == `MODULE_CODE)
        else $error("module code missing");
    // settled pin must show after two sync stages and the output register
    a_status_supply: assert property (
        $past(rst_b, 4) && supply_ok == $past(supply_ok, 1) &&
        supply_ok == $past(supply_ok, 2) &&
        supply_ok == $past(supply_ok, 3) |-> status_rdata[5] == supply_ok)
        else $error("status supply bit stale");
    a_force_toggle: assert property (
        $rose(status_rdata[7]) |-> status_rdata[6] != $past(status_rdata[6]))
        else $error("referencing without toggle");
    a_toggle_cause: assert property (
        $changed(status_rdata[6]) |-> $rose(status_rdata[7]))
        else $error("toggle without referencing");
    a_arm_clears: assert property (
        cfg_write && cfg_wdata[12] && !cfg_rdata[12]
        |-> ##[1:3] !status_rdata[7])
        else $error("arm did not clear referenced flag");
    a_rise_hold: assert property (
        status_rdata[11] && $past(status_rdata[11]) |-> $stable(rise_latch))
        else $error("rising latch recaptured");
    a_fall_hold: assert property (
        status_rdata[10] && $past(status_rdata[10]) |-> $stable(fall_latch))
        else $error("falling latch recaptured");
    a_rise_enabled: assert property (
        $rose(status_rdata[11]) |-> cfg_rdata[11])
        else $error("rising latch without enable");
    a_fall_enabled: assert property (
        $rose(status_rdata[10]) |-> cfg_rdata[10])
        else $error("falling latch without enable");
    a_homing_blocks: assert property (
        homing_active && $past(homing_active) && $past(homing_active, 2)
        |-> !$rose(status_rdata[11]) && !$rose(status_rdata[10]))
        else $error("latch taken during homing");
endmodule
bind enc_latch_force elf_checker chk (.clock(clock), .rst_b(rst_b),
    .supply_ok(supply_ok), .homing_active(homing_active),
    .cfg_write(cfg_write), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .status_rdata(status_rdata), .module_code_rdata(module_code_rdata),
    .rise_latch(rise_latch), .fall_latch(fall_latch));

/* verification/encoder_model.sv */
/* quadrature encoder with reference pulse and enable switch.
   assumes the bench calls its tasks; pins change after rising edges. */
`timescale 1ns/1ps
// ********
// encoder
// ********
module encoder_model (
    input wire clock,
    output reg enc_a,
    output reg enc_b,
    output reg ref_pulse,
    output reg ref_switch
);
    reg [1:0] phase;
    initial begin
        phase = 2'h0;
        enc_a = 1'b0;
        enc_b = 1'b0;
        ref_pulse = 1'b0;
        ref_switch = 1'b0;
    end
    // each state held four cycles so the two-flop sync never misses one
    task step(input integer n);
        integer i;
        begin
            for (i = 0; i < n; i = i + 1) begin
                repeat (4) @(posedge clock);
                phase = phase + 2'h1;
                enc_a <= phase[1];
                enc_b <= phase[1] ^ phase[0];
            end
        end
    endtask
    task set_ref(input v);
        begin
            @(posedge clock);
            ref_pulse <= v;
        end
    endtask
    task set_sw(input v);
        begin
            @(posedge clock);
            ref_switch <= v;
        end
    endtask
endmodule

/* verification/testbench.sv */
/* self-checking bench of enc_latch_force with an encoder model.
   assumes the registered output latencies of the block. */
`timescale 1ns/1ps
`include "enc_latch_defs.vh"
`define CHK(a, b) \
    begin \
        total_checks = total_checks + 1; \
        if ((a) !== (b)) begin \
            fails = fails + 1; \
            $display("CHECK FAILED t=%0t got %h exp %h", $time, a, b); \
        end \
    end
// ********
// bench
// ********
module testbench;
    reg clock = 1'b0;
    reg rst_b = 1'b0;
    reg clock_enable;
    reg supply_ok;
    reg homing_active;
    reg comparator_on;
    reg cfg_write, param1_write, param2_write;
    reg [15:0] cfg_wdata;
    reg [31:0] param1_wdata, param2_wdata;
    wire enc_a, enc_b, ref_pulse, ref_switch;
    wire [15:0] cfg_rdata, status_rdata, module_code_rdata;
    wire [31:0] counter_out, rise_latch, fall_latch;
    integer fails = 0;
    integer total_checks = 0;
    integer i;
    always #12.5 clock = ~clock;
    encoder_model enc (.clock(clock), .enc_a(enc_a), .enc_b(enc_b),
        .ref_pulse(ref_pulse), .ref_switch(ref_switch));
    enc_latch_force #(.WIDTH(32), .FILTER_LEN(4)) dut (.clock(clock),
        .rst_b(rst_b), .clock_enable(clock_enable), .enc_a(enc_a),
        .enc_b(enc_b), .ref_pulse(ref_pulse), .ref_switch(ref_switch),
        .supply_ok(supply_ok), .homing_active(homing_active),
        .comparator_on(comparator_on), .cfg_write(cfg_write),
        .cfg_wdata(cfg_wdata), .param1_write(param1_write),
        .param1_wdata(param1_wdata), .param2_write(param2_write),
        .param2_wdata(param2_wdata), .cfg_rdata(cfg_rdata),
        .status_rdata(status_rdata),
        .module_code_rdata(module_code_rdata),
        .counter_out(counter_out), .rise_latch(rise_latch),
        .fall_latch(fall_latch));
    // k selects the word: 0 control, 1 first parameter, 2 second
    task wr(input integer k, input [31:0] v);
        begin
            @(posedge clock);
            cfg_wdata <= v[15:0];
            param1_wdata <= v;
            param2_wdata <= v;
            cfg_write <= (k == 0);
            param1_write <= (k == 1);
            param2_write <= (k == 2);
            @(posedge clock);
            cfg_write <= 1'b0;
            param1_write <= 1'b0;
            param2_write <= 1'b0;
        end
    endtask
    task idle(input integer n);
        repeat (n) @(negedge clock);
    endtask
    // bound of 2000 cycles is the 50 us capture limit at 40 MHz
    task wait_st(input integer b, input v);
        integer n;
        begin
            n = 0;
            while (status_rdata[b] !== v && n < 2000) begin
                @(negedge clock);
                n = n + 1;
            end
            `CHK(status_rdata[b], v)
        end
    endtask
    task give_verdict;
        begin
            $display("checks %0d fails %0d", total_checks, fails);
            if (fails == 0 && total_checks > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    initial begin
        #500000;
        fails = fails + 1;
        give_verdict;
    end
    initial begin
        clock_enable <= 1'b1;
        supply_ok <= 1'b1;
        homing_active <= 1'b0;
        comparator_on <= 1'b0;
        cfg_write <= 1'b0;
        param1_write <= 1'b0;
        param2_write <= 1'b0;
        cfg_wdata <= 16'h0000;
        param1_wdata <= 32'h0;
        param2_wdata <= 32'h0;
        repeat (8) @(posedge clock);
        rst_b <= 1'b1;
        idle(4);
        `CHK(cfg_rdata, 16'h0000)
        `CHK(module_code_rdata[15:8], `MODULE_CODE)
        `CHK(status_rdata[5], 1'b1)
        @(posedge clock);
        supply_ok <= 1'b0;
        wr(0, 32'hc0ff);
        idle(4);
        `CHK(cfg_rdata, 16'h0000)
        `CHK(status_rdata[5], 1'b0)
        wr(2, 32'h0001_2340);
        wr(0, 32'h0100);
        wr(0, 32'h1000);
        enc.set_sw(1'b1);
        wait_st(7, 1'b1);
        idle(2);
        `CHK(counter_out, 32'h0001_2340)
        `CHK(status_rdata[6], 1'b1)
        `CHK(status_rdata[1], 1'b1)
        wr(2, 32'h0000_0555);
        wr(0, 32'h2100);
        idle(3);
        wr(0, 32'h3000);
        idle(3);
        `CHK(status_rdata[7], 1'b0)
        enc.set_sw(1'b0);
        wait_st(7, 1'b1);
        idle(2);
        `CHK(counter_out, 32'h0000_0555)
        `CHK(status_rdata[6], 1'b0)
        wr(0, 32'h0800);
        idle(3);
        enc.set_ref(1'b1);
        wait_st(11, 1'b1);
        idle(1);
        `CHK(rise_latch, 32'h0000_0555)
        enc.set_ref(1'b0);
        // move the count so that a second capture would show
        enc.step(4);
        idle(20);
        enc.set_ref(1'b1);
        idle(20);
        `CHK(status_rdata[11], 1'b1)
        `CHK(rise_latch, 32'h0000_0555)
        wr(0, 32'h0);
        wait_st(11, 1'b0);
        wr(0, 32'h0400);
        idle(3);
        enc.set_ref(1'b0);
        wait_st(10, 1'b1);
        idle(1);
        `CHK(fall_latch, 32'h0000_0559)
        wr(0, 32'h0);
        wait_st(10, 1'b0);
        // start state 1 against a low pin must yield a falling edge
        wr(0, 32'h0600);
        wait_st(10, 1'b1);
        wr(0, 32'h0);
        wait_st(10, 1'b0);
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge clock);
            homing_active <= (i == 0);
            comparator_on <= (i == 1);
            wr(0, 32'h0800);
            enc.set_ref(1'b1);
            idle(40);
            `CHK(status_rdata[11], 1'b0)
            enc.set_ref(1'b0);
            idle(20);
            wr(0, 32'h0);
        end
        @(posedge clock);
        homing_active <= 1'b0;
        comparator_on <= 1'b0;
        wr(1, 32'h2);
        wr(0, 32'h0100);
        wr(0, 32'h0800);
        idle(3);
        enc.set_ref(1'b1);
        idle(40);
        `CHK(status_rdata[11], 1'b0)
        enc.set_ref(1'b0);
        // either count direction gives an unsigned difference above 2
        enc.step(4);
        idle(4);
        enc.set_ref(1'b1);
        wait_st(11, 1'b1);
        idle(1);
        `CHK(rise_latch == 32'h55d || rise_latch == 32'h54d, 1'b1)
        // a frozen block must ignore both the pins and a clearing write
        @(posedge clock);
        clock_enable <= 1'b0;
        wr(0, 32'h0);
        enc.step(4);
        @(posedge clock);
        clock_enable <= 1'b1;
        idle(8);
        `CHK(cfg_rdata, 16'h0800)
        `CHK(status_rdata[11], 1'b1)
        `CHK(counter_out, 32'h0000_055d)
        give_verdict;
    end
endmodule
